/* rtl/psi_pkg.sv */
// Package for the PHY status and interrupt block: map, fields and types.
// Functional notes
// - Bits 14/13 show speed and duplex.
// - Bit 12 latches page received until cleared.
// - Bit 11 high when negotiation done or off.
// - Bit 10 shows current link state.
// - Bit 8 shows crossed wiring in use.
// - Bit 6 shows core sleeping.
// - Bit 1 shows ten megabit polarity.
// - Bit 0 shows jabber; reserved bits zero.
// - Mask enables at documented bits; rest reserved.
// - Mask bit 1 enables; resets to zero.
// - Event bit 15 latches negotiation error.
// - Event bit 14 latches speed change.
// - Event bit 13 latches duplex change.
// - Event bit 12 latches page received.
// - Event bit 11 latches negotiation complete.
// - Event bit 10 latches link change.
// - Event bit 7 latches elastic buffer error.
// - Event bit 6 latches crossover change.
// - Event bit 4 latches sleep change.
// - Event bit 1 latches polarity change.
// - Event bit 0 latches jabber detected.
// - Polarity 1 gives active low pin.
package psi_pkg;
  localparam logic [7:0]  IDX_STATUS  = 8'h11;
  localparam logic [7:0]  IDX_MASK    = 8'h12;
  localparam logic [7:0]  IDX_EVENT   = 8'h13;
  localparam logic [7:0]  IDX_CTRL    = 8'h14;
  localparam logic [7:0]  A_STATUS    = {IDX_STATUS[5:0], 2'h0};
  localparam logic [7:0]  A_MASK      = {IDX_MASK[5:0], 2'h0};
  localparam logic [7:0]  A_EVENT     = {IDX_EVENT[5:0], 2'h0};
  localparam logic [7:0]  A_CTRL      = {IDX_CTRL[5:0], 2'h0};
  localparam int          S_SPEED     = 14;
  localparam int          S_DUPLEX    = 13;
  localparam int          S_PAGE      = 12;
  localparam int          S_ANDONE    = 11;
  localparam int          S_LINK      = 10;
  localparam int          S_XOVER     = 8;
  localparam int          S_SLEEP     = 6;
  localparam int          S_POL       = 1;
  localparam int          S_JAB       = 0;
  localparam int          E_ANERR     = 15;
  localparam int          E_SPEED     = 14;
  localparam int          E_DUPLEX    = 13;
  localparam int          E_PAGE      = 12;
  localparam int          E_ANDONE    = 11;
  localparam int          E_LINK      = 10;
  localparam int          E_FIFO      = 7;
  localparam int          E_XOVER     = 6;
  localparam int          E_SLEEP     = 4;
  localparam int          E_POL       = 1;
  localparam int          E_JAB       = 0;
  localparam int          C_POL       = 13;
  localparam logic [15:0] MASK_WMASK  = 16'hFCD3;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [15:0] EVENT_RST   = 16'h0000;
  localparam logic        POL_RST     = 1'b1;

  typedef struct packed {
    logic speed;
    logic duplex;
    logic page_rx;
    logic an_enabled;
    logic an_done;
    logic link_up;
    logic crossed_wiring;
    logic sleep;
    logic rx_polarity;
    logic jabber;
    logic an_error;
    logic fifo_err;
  } psi_phy_t;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] ev;
    logic        page;
    logic        pol;
    logic [5:0]  prev;
    logic        an_prev;
    logic        jab_prev;
    logic        primed;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
    logic        pin;
  } psi_state_t;
endpackage

/* rtl/psi_top.sv */
// PHY status, event latching and interrupt pin logic behind an APB slave.
`timescale 1ns/1ps
module psi_top
  import psi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire psi_phy_t    phy,
  output logic             int_pin
);

  logic       rst_meta_q;
  logic       rst_n_q;
  psi_state_t s_q;
  psi_state_t s_d;

  // Reset is asserted at once and released two edges later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  logic [5:0]  cur;
  logic [15:0] status;
  logic [15:0] new_ev;
  logic        access;
  logic        done;
  logic        mapped;
  logic        irq;

  assign cur = {phy.speed, phy.duplex, phy.link_up,
                phy.crossed_wiring, phy.sleep, phy.rx_polarity};
  assign access = psel && penable;
  assign done = access && s_q.ready;
  assign mapped = (paddr == A_STATUS) || (paddr == A_MASK) ||
                  (paddr == A_EVENT) || (paddr == A_CTRL);

  always_comb begin
    status = 16'h0000;
    status[S_SPEED]  = phy.speed;
    status[S_DUPLEX] = phy.duplex;
    status[S_PAGE]   = s_q.page;
    status[S_ANDONE] = phy.an_done || !phy.an_enabled;
    status[S_LINK]   = phy.link_up;
    status[S_XOVER]  = phy.crossed_wiring;
    status[S_SLEEP]  = phy.sleep;
    status[S_POL]    = phy.rx_polarity;
    status[S_JAB]    = phy.jabber;
  end

  always_comb begin
    new_ev = 16'h0000;
    new_ev[E_ANERR]  = phy.an_error;
    new_ev[E_SPEED]  = s_q.primed && (cur[5] != s_q.prev[5]);
    new_ev[E_DUPLEX] = s_q.primed && (cur[4] != s_q.prev[4]);
    new_ev[E_PAGE]   = phy.page_rx;
    new_ev[E_ANDONE] = s_q.primed && phy.an_done && !s_q.an_prev;
    new_ev[E_LINK]   = s_q.primed && (cur[3] != s_q.prev[3]);
    new_ev[E_FIFO]   = phy.fifo_err;
    new_ev[E_XOVER]  = s_q.primed && (cur[2] != s_q.prev[2]);
    new_ev[E_SLEEP]  = s_q.primed && (cur[1] != s_q.prev[1]);
    new_ev[E_POL]    = s_q.primed && (cur[0] != s_q.prev[0]);
    new_ev[E_JAB]    = s_q.primed && phy.jabber && !s_q.jab_prev;
  end

  always_comb begin
    s_d          = s_q;
    s_d.prev     = cur;
    s_d.an_prev  = phy.an_done;
    s_d.jab_prev = phy.jabber;
    // Change detection waits one cycle so reset values raise no event.
    s_d.primed   = 1'b1;
    s_d.ready    = 1'b0;
    s_d.err      = 1'b0;
    // Only reported bits clear, so an event in the wait state stays pending.
    // clear on read, new events win
    if (done && !pwrite && paddr == A_EVENT) begin
      s_d.ev = (s_q.ev & ~s_q.rdata[15:0]) | new_ev;
    end else begin
      s_d.ev = s_q.ev | new_ev;
    end
    if (done && !pwrite && paddr == A_STATUS) begin
      s_d.page = (s_q.page && !s_q.rdata[S_PAGE]) || phy.page_rx;
    end else begin
      s_d.page = s_q.page || phy.page_rx;
    end
    // One wait state: data is captured on the same edge that raises pready.
    if (access && !s_q.ready) begin
      s_d.ready = 1'b1;
      s_d.err   = !mapped;
      s_d.rdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          A_STATUS: s_d.rdata[15:0] = status;
          A_MASK:   s_d.rdata[15:0] = s_q.mask;
          A_EVENT:  s_d.rdata[15:0] = s_q.ev;
          A_CTRL:   s_d.rdata[C_POL] = s_q.pol;
          default:  s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (done && pwrite) begin
      if (paddr == A_MASK) begin
        s_d.mask = pwdata[15:0] & MASK_WMASK;
      end
      if (paddr == A_CTRL) begin
        s_d.pol = pwdata[C_POL];
      end
    end
    irq     = |(s_d.ev & s_d.mask);
    s_d.pin = s_d.pol ? !irq : irq;
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q          <= '0;
      s_q.mask     <= MASK_RST;
      s_q.ev       <= EVENT_RST;
      s_q.pol      <= POL_RST;
      s_q.pin      <= POL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready  = s_q.ready;
  assign pslverr = s_q.err;
  assign prdata  = s_q.rdata;
  assign int_pin = s_q.pin;

  // Checks; all share the core clock and the released reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  logic rd_status;
  assign rd_status = access && !s_q.ready && !pwrite &&
                     paddr == A_STATUS;

  property p_speed_duplex;
    rd_status |=> prdata[S_SPEED] == $past(phy.speed) &&
                  prdata[S_DUPLEX] == $past(phy.duplex);
  endproperty
  a_speed_duplex: assert property (p_speed_duplex)
    else $error("speed or duplex bit wrong");

  property p_page_latch;
    phy.page_rx |=> s_q.page;
  endproperty
  a_page_latch: assert property (p_page_latch)
    else $error("page bit not latched");

  property p_an_done;
    rd_status |=> prdata[S_ANDONE] ==
      ($past(phy.an_done) || !$past(phy.an_enabled));
  endproperty
  a_an_done: assert property (p_an_done)
    else $error("negotiation done bit wrong");

  property p_link_state;
    rd_status |=> prdata[S_LINK] == $past(phy.link_up) &&
                  prdata[15] == 1'b0;
  endproperty
  a_link_state: assert property (p_link_state)
    else $error("link bit wrong");

  property p_mask_reserved;
    (s_q.mask & ~MASK_WMASK) == 16'h0000;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bit set");

  property p_anerr_event;
    phy.an_error |=> s_q.ev[E_ANERR];
  endproperty
  a_anerr_event: assert property (p_anerr_event)
    else $error("negotiation error not latched");

  property p_speed_event;
    s_q.primed && phy.speed != s_q.prev[5] |=> s_q.ev[E_SPEED];
  endproperty
  a_speed_event: assert property (p_speed_event)
    else $error("speed change not latched");

  property p_link_event;
    s_q.primed && $changed(phy.link_up) |=> s_q.ev[E_LINK];
  endproperty
  a_link_event: assert property (p_link_event)
    else $error("link change not latched");

  property p_jab_event;
    s_q.primed && $rose(phy.jabber) |=> s_q.ev[E_JAB];
  endproperty
  a_jab_event: assert property (p_jab_event)
    else $error("jabber not latched");

  property p_pin;
    int_pin == (s_q.pol ^ (|(s_q.ev & s_q.mask)));
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin wrong");

  property p_clear_read;
    done && !pwrite && paddr == A_EVENT && new_ev == 16'h0000
      |=> (s_q.ev & $past(prdata[15:0])) == 16'h0000;
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("event register not cleared by read");

  property p_ready_pulse;
    s_q.ready |=> !s_q.ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held over two cycles");

  property p_xover_state;
    rd_status |=> prdata[S_XOVER] == $past(phy.crossed_wiring);
  endproperty
  a_xover_state: assert property (p_xover_state)
    else $error("crossover bit wrong");

  property p_sleep_state;
    rd_status |=> prdata[S_SLEEP] == $past(phy.sleep);
  endproperty
  a_sleep_state: assert property (p_sleep_state)
    else $error("sleep bit wrong");

  property p_pol_state;
    rd_status |=> prdata[S_POL] == $past(phy.rx_polarity);
  endproperty
  a_pol_state: assert property (p_pol_state)
    else $error("polarity bit wrong");

  property p_jab_state;
    rd_status |=> prdata[S_JAB] == $past(phy.jabber) &&
                  prdata[9] == 1'b0 && prdata[7] == 1'b0 &&
                  prdata[5:2] == 4'h0;
  endproperty
  a_jab_state: assert property (p_jab_state)
    else $error("jabber or reserved status bit wrong");

  property p_mask_store;
    done && pwrite && paddr == A_MASK
      |=> s_q.mask == ($past(pwdata[15:0]) & MASK_WMASK);
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("mask write not stored");

  property p_pin_idle;
    (s_q.ev & s_q.mask) == 16'h0000 |-> int_pin == s_q.pol;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("pin active with no enabled event");

  property p_duplex_event;
    s_q.primed && phy.duplex != s_q.prev[4] |=> s_q.ev[E_DUPLEX];
  endproperty
  a_duplex_event: assert property (p_duplex_event)
    else $error("duplex change not latched");

  property p_page_event;
    phy.page_rx |=> s_q.ev[E_PAGE];
  endproperty
  a_page_event: assert property (p_page_event)
    else $error("page event not latched");

  property p_andone_event;
    s_q.primed && $rose(phy.an_done) |=> s_q.ev[E_ANDONE];
  endproperty
  a_andone_event: assert property (p_andone_event)
    else $error("negotiation completion not latched");

  property p_fifo_event;
    phy.fifo_err |=> s_q.ev[E_FIFO];
  endproperty
  a_fifo_event: assert property (p_fifo_event)
    else $error("buffer error not latched");

  property p_xover_event;
    s_q.primed && $changed(phy.crossed_wiring) |=> s_q.ev[E_XOVER];
  endproperty
  a_xover_event: assert property (p_xover_event)
    else $error("crossover change not latched");

  property p_sleep_event;
    s_q.primed && $changed(phy.sleep) |=> s_q.ev[E_SLEEP];
  endproperty
  a_sleep_event: assert property (p_sleep_event)
    else $error("sleep change not latched");

  property p_pol_event;
    s_q.primed && $changed(phy.rx_polarity) |=> s_q.ev[E_POL];
  endproperty
  a_pol_event: assert property (p_pol_event)
    else $error("polarity change not latched");

  property p_pin_active;
    |(s_q.ev & s_q.mask) |-> int_pin == !s_q.pol;
  endproperty
  a_pin_active: assert property (p_pin_active)
    else $error("pin level does not follow polarity");

  property p_page_clear;
    done && !pwrite && paddr == A_STATUS && !phy.page_rx
      |=> !(s_q.page && $past(prdata[S_PAGE]));
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("reported page bit not cleared by read");

  property p_unmapped_err;
    access && !s_q.ready && !mapped
      |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");

  property p_event_reserved;
    (s_q.ev & ~MASK_WMASK) == 16'h0000;
  endproperty
  a_event_reserved: assert property (p_event_reserved)
    else $error("reserved event bit set");

  property p_rdata_high;
    s_q.ready |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rdata_high: assert property (p_rdata_high)
    else $error("upper read data not zero");

  property p_event_read;
    done && !pwrite && paddr == A_EVENT;
  endproperty
  c_event_read: cover property (p_event_read);

  property p_mask_write;
    done && pwrite && paddr == A_MASK;
  endproperty
  c_mask_write: cover property (p_mask_write);

  property p_irq_seen;
    |(s_q.ev & s_q.mask);
  endproperty
  c_irq_seen: cover property (p_irq_seen);

  property p_unmapped;
    s_q.ready && s_q.err;
  endproperty
  c_unmapped: cover property (p_unmapped);

endmodule // psi_top

/* verif/psi_host.sv */
// Management host model: APB master that reads and writes the registers.
`timescale 1ns/1ps
module psi_host (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q  = prdata;
    e  = pslverr;
    ok = (n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value is never mistaken.
    pwdata  <= ~d;
  endtask
endmodule // psi_host

/* verif/psi_top_tb.sv */
// Self-checking testbench for the PHY status and interrupt block.
`timescale 1ns/1ps
module psi_top_tb;
  import psi_pkg::*;
  logic        clk = 1'b0;
  logic        nrst;
  logic        psel, penable, pwrite, pready, pslverr, int_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  psi_phy_t    phy;
  int          err_total = 0;
  int          comparisons = 0;

  always #2.5 clk = ~clk;

  psi_host host (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  psi_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .phy(phy), .int_pin(int_pin));

  task automatic summarize();
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    logic ok;
    host.xfer(w, a, d, q, e, ok);
    if (ok !== 1'b1) begin
      err_total++;
      summarize();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    bus(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    bus(1'b1, a, d, q, e);
  endtask

  task automatic wait_chk_pin(input int n, input logic exp);
    repeat (n) @(posedge clk);
    #1 chk(int_pin, exp);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    wait_chk_pin(0, 1'b1);
    rd(A_STATUS, 32'h0);
    rd(A_MASK, 32'h0);
    rd(A_EVENT, 32'h0);
    bus(1'b0, 8'h00, 32'h0, q, e);
    chk(q, 32'h0);
    chk(e, 1'b1);
    wr(A_MASK, 32'hFFFF);
    rd(A_MASK, 32'hFCD3);
    wr(A_EVENT, 32'hFFFF);
    rd(A_EVENT, 32'h0);
  endtask

  task automatic t_events();
    int b[11] = '{15, 14, 13, 12, 11, 10, 7, 6, 4, 1, 0};
    int k[11] = '{1, 11, 10, 9, 7, 6, 0, 5, 4, 3, 2};
    for (int i = 0; i < 11; i++) begin
      wr(A_MASK, 32'h1 << b[i]);
      @(posedge clk);
      phy[k[i]] <= ~phy[k[i]];
      // Page, error and buffer sources are one-cycle pulses.
      if (k[i] inside {0, 1, 9}) begin
        @(posedge clk);
        phy[k[i]] <= 1'b0;
      end
      wait_chk_pin(2, 1'b0);
      rd(A_EVENT, 32'h1<<b[i]);
      wait_chk_pin(1, 1'b1);
    end
  endtask

  task automatic t_status();
    rd(A_STATUS, 32'h7D43);
    rd(A_STATUS, 32'h6D43);
    @(posedge clk);
    phy <= 12'h000;
    rd(A_STATUS, 32'h0800);
    @(posedge clk);
    phy <= 12'h100;
    rd(A_STATUS, 32'h0);
    rd(A_EVENT, 32'h6452);
  endtask

  task automatic t_pol();
    wr(A_MASK, 32'h0);
    @(posedge clk);
    phy.link_up <= 1'b1;
    wait_chk_pin(2, 1'b1);
    rd(A_EVENT, 32'h0400);
    wr(A_CTRL, 32'h0);
    wait_chk_pin(1, 1'b0);
    wr(A_MASK, 32'h0400);
    @(posedge clk);
    phy.link_up <= 1'b0;
    wait_chk_pin(2, 1'b1);
    rd(A_EVENT, 32'h0400);
    wait_chk_pin(1, 1'b0);
    wr(A_CTRL, 32'h2000);
    rd(A_CTRL, 32'h2000);
  endtask

  initial begin
    nrst = 1'b0;
    phy  = 12'h100;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_events();
    t_status();
    t_pol();
    summarize();
  end
endmodule // psi_top_tb
